// ===== common/pwr_pkg.sv
package pwr_pkg;

  // ---------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_POWER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_AUX_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_IRQ_PRIORITY = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // Power control register fields
  localparam int POWER_CONTROL_REG_IDLE_BIT = 0;
  localparam int POWER_CONTROL_REG_PD_BIT = 1;
  localparam int POWER_CONTROL_REG_POF_BIT = 4;
  localparam int POWER_CONTROL_REG_BOF_BIT = 5;
  // Auxiliary control register fields
  localparam int AUX_BOI_BIT = 5;
  localparam int AUX_BOD_BIT = 6;
  // Configuration register fields
  localparam int CFG_WATCHDOG_ENABLE_CFG_BIT = 0;
  localparam int CFG_BOV_BIT = 1;
  localparam int CFG_RSTEN_BIT = 2;
  localparam int CFG_XTAL_BIT = 3;
  localparam int CFG_ADC_RC_BIT = 4;
  // Wake source index within enable and priority registers
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_KBD = 2;
  localparam int SRC_CMP1 = 3;
  localparam int SRC_CMP2 = 4;
  localparam int SRC_WDT = 5;
  localparam int SRC_BO = 6;
  localparam int SRC_ADC = 7;

  localparam logic [7:0] POWER_CONTROL_REG_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Oscillator settle counts
  // ---------------------------------------------------------------
  localparam int XTAL_SETTLE_CLKS = 1024;
  localparam int RC_SETTLE_CLKS = 256;
  localparam int SETTLE_W = 11;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_SETTLE
  } pmode_e;

  typedef struct packed {
    logic ext0;
    logic ext1;
    logic kbd;
    logic cmp1;
    logic cmp2;
    logic wdt_irq;
    logic adc;
  } wake_src_s;

  typedef struct packed {
    logic kbd_ready;
    logic cmp1_ready;
    logic cmp2_ready;
    logic adc_ready;
  } src_setup_s;

endpackage

// ===== tb/pwr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic BROWNOUT_LOW,
  input wire logic CPU_HALT,
  input wire logic OSC_RUN,
  input wire logic PERIPH_CLK_EN,
  input wire logic BROWNOUT_EN,
  input wire logic BROWNOUT_IRQ,
  input wire logic SYS_RESET,
  input wire logic WAKE_RESUME
);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic [1:0] aux_q;
  logic [10:0] run_q;
  wire aux_wr = WR && ADDR == pwr_pkg::ADDR_AUX_CONTROL;
  wire pc_wr = WR && ADDR == pwr_pkg::ADDR_POWER_CONTROL && !SYS_RESET;
  always_ff @(posedge CLK) begin
    if (!RST_N) aux_q <= 2'h0;
    else if (aux_wr) aux_q <= WDATA[6:5];
  end
  // Clocks since the oscillator came back
  always_ff @(posedge CLK) begin
    if (!RST_N || !OSC_RUN) run_q <= 11'h000;
    else if (run_q != 11'h7ff) run_q <= run_q + 11'h001;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  bo_disable_a: assert property (aux_wr |=> ##1 BROWNOUT_EN == !aux_q[1])
    else $error("brownout enable wrong");
  idle_entry_a: assert property (
    pc_wr && WDATA[1:0] == 2'h1 |=> CPU_HALT && OSC_RUN && PERIPH_CLK_EN)
    else $error("idle entry wrong");
  pd_entry_a: assert property (
    pc_wr && WDATA[1] && !BROWNOUT_LOW |=> CPU_HALT && !OSC_RUN && !PERIPH_CLK_EN)
    else $error("power down entry wrong");
  settle_count_a: assert property (WAKE_RESUME |->
    run_q == 11'(pwr_pkg::RC_SETTLE_CLKS) || run_q == 11'(pwr_pkg::XTAL_SETTLE_CLKS))
    else $error("resume before settle count");
  resume_run_a: assert property (WAKE_RESUME |=> !WAKE_RESUME && !CPU_HALT)
    else $error("resume pulse wrong");
  bo_irq_once_a: assert property (
    BROWNOUT_IRQ |-> $past(BROWNOUT_LOW) ##1 !BROWNOUT_IRQ)
    else $error("brownout interrupt wrong");
  bo_reset_a: assert property (
    BROWNOUT_LOW && BROWNOUT_EN && !aux_q[0] |-> ##[1:2] SYS_RESET)
    else $error("brownout reset missing");
  reset_exit_a: assert property ($rose(SYS_RESET) |-> ##[0:1] !CPU_HALT && OSC_RUN)
    else $error("reset did not leave low power");
  wake_c: cover property (WAKE_RESUME);
  bo_irq_c: cover property (BROWNOUT_IRQ);
  sys_rst_c: cover property (SYS_RESET);
endmodule // pwr_monitor
bind power_mode_wakeup_control pwr_monitor mon_u (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Bench signals and tasks
  // ------------------------------------------------------------
  localparam logic [3:0] a_pc = pwr_pkg::ADDR_POWER_CONTROL;
  localparam logic [3:0] a_aux = pwr_pkg::ADDR_AUX_CONTROL;
  localparam logic [3:0] a_ien = pwr_pkg::ADDR_IRQ_ENABLE;
  localparam logic [3:0] a_st = pwr_pkg::ADDR_STATUS;
  logic clk, rst_n, wr, rd, pwrup, bo_low, gie, a_valid, wdt_ovf, rst_pin_n;
  logic halt, osc, pclk, bo_en, bo_irq, sys_rst, resume;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, cfg;
  logic [1:0] a_prio;
  pwr_pkg::wake_src_s wake;
  pwr_pkg::wake_src_s fire;
  pwr_pkg::src_setup_s setup;
  int num_errors, samples_checked, i;
  power_mode_wakeup_control dut_u (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .POWER_UP_DETECT(pwrup), .BROWNOUT_LOW(bo_low),
    .EXT_RESET_N(rst_pin_n), .WDT_OVERFLOW(wdt_ovf), .GLOBAL_IRQ_EN(gie),
    .ACTIVE_PRIORITY(a_prio), .ACTIVE_VALID(a_valid), .WAKE_SRC(wake), .SRC_SETUP(setup),
    .CPU_HALT(halt),
    .OSC_RUN(osc), .PERIPH_CLK_EN(pclk), .BROWNOUT_EN(bo_en), .BROWNOUT_IRQ(bo_irq),
    .SYS_RESET(sys_rst), .WAKE_RESUME(resume));
  wake_source_model src_u (.clk(clk), .rst_n(rst_n), .fire(fire), .cpu_halt(halt),
    .wake_src(wake), .cfg_byte(cfg));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    #1;
    for (i = 0; i < 1100 && s !== v; i++) step(1);
    if (i == 1100) begin
      chk(1'b0, 1'b1);
      end_sim();
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic kick(input pwr_pkg::wake_src_s m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= '0;
    #1;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, pwrup, bo_low, a_valid, wdt_ovf, fire, setup, addr, wdata, a_prio} = '0;
    gie = 1'b1;
    rst_pin_n = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    step(1);
    chk({halt, osc, pclk, bo_en, sys_rst}, 5'h0e);
    rd_chk(4'hf, 8'h00);
    @(posedge clk);
    pwrup <= 1'b1;
    @(posedge clk);
    pwrup <= 1'b0;
    wait_for(sys_rst, 1'b1);
    wait_for(sys_rst, 1'b0);
    rd_chk(a_pc, 8'h10);
    wr_reg(a_pc, 8'h00);
    rd_chk(a_pc, 8'h00);
    $display("power-on test done");
    wr_reg(pwr_pkg::ADDR_CONFIG, cfg);
    wr_reg(a_ien, 8'h01);
    wr_reg(a_pc, 8'h01);
    chk({halt, osc, pclk}, 3'h7);
    rd_chk(a_st, 8'h01);
    kick(7'h40);
    wait_for(halt, 1'b0);
    rd_chk(a_pc, 8'h00);
    $display("idle test done");
    @(posedge clk);
    a_valid <= 1'b1;
    a_prio <= 2'h1;
    wr_reg(a_pc, 8'h02);
    chk({halt, osc, pclk}, 3'h4);
    kick(7'h40);
    step(20);
    chk(osc, 1'b0);
    rd_chk(a_st, 8'h02);
    @(posedge clk);
    a_valid <= 1'b0;
    wait_for(osc, 1'b1);
    wait_for(resume, 1'b1);
    chk(i >= 255 && i <= 257, 1'b1);
    step(1);
    chk(halt, 1'b0);
    rd_chk(a_pc, 8'h00);
    $display("power down test done");
    wr_reg(a_aux, 8'h40);
    step(1);
    chk(bo_en, 1'b0);
    wr_reg(a_aux, 8'h20);
    wr_reg(a_ien, 8'h40);
    wr_reg(a_pc, 8'h02);
    chk(bo_en, 1'b1);
    @(posedge clk);
    bo_low <= 1'b1;
    wait_for(bo_irq, 1'b1);
    wait_for(osc, 1'b1);
    wait_for(resume, 1'b1);
    chk(sys_rst, 1'b0);
    rd_chk(a_pc, 8'h20);
    @(posedge clk);
    bo_low <= 1'b0;
    wr_reg(a_aux, 8'h00);
    @(posedge clk);
    bo_low <= 1'b1;
    wait_for(sys_rst, 1'b1);
    chk(bo_irq, 1'b0);
    @(posedge clk);
    bo_low <= 1'b0;
    wait_for(sys_rst, 1'b0);
    $display("brownout test done");
    wr_reg(pwr_pkg::ADDR_CONFIG, 8'h01);
    wr_reg(a_pc, 8'h02);
    chk({halt, osc}, 2'h2);
    @(posedge clk);
    wdt_ovf <= 1'b1;
    @(posedge clk);
    wdt_ovf <= 1'b0;
    #1;
    chk({halt, osc, sys_rst}, 3'h3);
    rd_chk(a_pc, 8'h00);
    wr_reg(a_ien, 8'h20);
    wr_reg(a_pc, 8'h02);
    kick(7'h02);
    step(4);
    chk(osc, 1'b0);
    wr_reg(pwr_pkg::ADDR_CONFIG, 8'h00);
    wait_for(osc, 1'b1);
    wait_for(resume, 1'b1);
    $display("watchdog test done");
    wr_reg(a_pc, 8'h02);
    @(posedge clk);
    rst_pin_n <= 1'b0;
    step(4);
    chk({osc, sys_rst}, 2'h0);
    wr_reg(pwr_pkg::ADDR_CONFIG, 8'h04);
    wait_for(sys_rst, 1'b1);
    chk({halt, osc}, 2'h1);
    @(posedge clk);
    rst_pin_n <= 1'b1;
    wait_for(sys_rst, 1'b0);
    wr_reg(pwr_pkg::ADDR_CONFIG, 8'h00);
    $display("reset pin test done");
    wr_reg(a_ien, 8'h04);
    wr_reg(a_pc, 8'h02);
    kick(7'h10);
    step(4);
    chk(osc, 1'b0);
    @(posedge clk);
    setup <= 4'h8;
    wait_for(osc, 1'b1);
    wait_for(resume, 1'b1);
    @(posedge clk);
    setup <= 4'h1;
    wr_reg(a_ien, 8'h80);
    wr_reg(a_pc, 8'h02);
    kick(7'h01);
    step(4);
    chk(osc, 1'b0);
    wr_reg(pwr_pkg::ADDR_CONFIG, 8'h18);
    wait_for(osc, 1'b1);
    wait_for(resume, 1'b1);
    chk(i, 11'(pwr_pkg::XTAL_SETTLE_CLKS));
    $display("source setup test done");
    end_sim();
  end
endmodule // tb
`default_nettype wire

// ===== tb/wake_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire pwr_pkg::wake_src_s fire,
  input wire logic cpu_halt,
  output var pwr_pkg::wake_src_s wake_src,
  output logic [7:0] cfg_byte
);
  // ------------------------------------------------------------
  // Interrupt sources, each held until the core runs again
  // ------------------------------------------------------------
  pwr_pkg::wake_src_s pend_q;
  always_ff @(posedge clk) begin
    if (!rst_n) pend_q <= '0;
    else if (fire != '0) pend_q <= pend_q | fire;
    else if (!cpu_halt) pend_q <= '0;
  end
  assign wake_src = pend_q;
  // RC clock, voltage select zero, reset pin off
  assign cfg_byte = 8'h00;
endmodule // wake_source_model
`default_nettype wire

// ===== verilog/power_mode_wakeup_control.sv
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Brownout detector off while disable bit set
// - Power-up sets power-on flag until cleared
// - Idle request halts CPU, peripherals keep running
// - Idle ends on enabled interrupt or reset
// - Power-down request stops main oscillator
// - Power down exits on reset or priority wake
// - Watchdog keeps counting and may reset in power down
// - Brownout reset acts immediately, also in power down
// - Enabled brownout interrupt wakes from power down
// - Wake restarts oscillator, waits 1024 or 256 clocks
// - Detector, watchdog, comparators, converter run in power down
// - External wake needs enable; keyboard, comparator wake need setup and enable
// - Watchdog reset or interrupt wake per enable bit
// - Brownout wake needs disable clear, select chooses kind
// - Reset pin wakes only when function enabled
// - Converter wakes only with RC clock, setup, enable
// - Brownout resets by default, interrupt when selected
// - Brownout interrupt once on falling crossing
// - Brownout sets sticky flag until software clears
module power_mode_wakeup_control (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic POWER_UP_DETECT,
  input wire logic BROWNOUT_LOW,
  input wire logic EXT_RESET_N,
  input wire logic WDT_OVERFLOW,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic [1:0] ACTIVE_PRIORITY,
  input wire logic ACTIVE_VALID,
  input wire pwr_pkg::wake_src_s WAKE_SRC,
  input wire pwr_pkg::src_setup_s SRC_SETUP,
  output logic CPU_HALT,
  output logic OSC_RUN,
  output logic PERIPH_CLK_EN,
  output logic BROWNOUT_EN,
  output logic BROWNOUT_IRQ,
  output logic SYS_RESET,
  output logic WAKE_RESUME
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] power_control_reg_q;
  logic [7:0] power_control_reg_d;
  logic [7:0] aux_q;
  logic [7:0] cfg_q;
  logic [7:0] ien_q;
  logic [7:0] ipr_q;
  pwr_pkg::pmode_e mode_q;
  pwr_pkg::pmode_e mode_d;
  logic [pwr_pkg::SETTLE_W-1:0] settle_q;
  logic [pwr_pkg::SETTLE_W-1:0] settle_d;
  logic bo_low_q;
  logic [7:0] rdata_d;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire wr_power_control_reg = WR && (ADDR == pwr_pkg::ADDR_POWER_CONTROL);
  wire wr_aux = WR && (ADDR == pwr_pkg::ADDR_AUX_CONTROL);
  wire wr_cfg = WR && (ADDR == pwr_pkg::ADDR_CONFIG);
  wire wr_ien = WR && (ADDR == pwr_pkg::ADDR_IRQ_ENABLE);
  wire wr_ipr = WR && (ADDR == pwr_pkg::ADDR_IRQ_PRIORITY);

  wire bo_disable = aux_q[pwr_pkg::AUX_BOD_BIT];
  wire bo_irq_sel = aux_q[pwr_pkg::AUX_BOI_BIT];
  wire wdt_en_cfg = cfg_q[pwr_pkg::CFG_WATCHDOG_ENABLE_CFG_BIT];
  wire rst_pin_en = cfg_q[pwr_pkg::CFG_RSTEN_BIT];
  wire xtal_cfg = cfg_q[pwr_pkg::CFG_XTAL_BIT];
  wire adc_rc_clock_select = cfg_q[pwr_pkg::CFG_ADC_RC_BIT];

  // Source may request service: enabled, globally enabled, priority above active
  function automatic logic qualify(input logic req, input int idx);
    qualify = req && ien_q[idx] && GLOBAL_IRQ_EN &&
      (!ACTIVE_VALID || (ipr_q[idx] && ACTIVE_PRIORITY == 2'h0));
  endfunction

  // ---------------------------------------------------------------
  // Brownout detection
  // ---------------------------------------------------------------
  wire bo_active = BROWNOUT_LOW && !bo_disable;
  wire bo_fall = bo_active && !bo_low_q;
  wire bo_reset = bo_active && !bo_irq_sel;
  wire bo_irq_evt = bo_fall && bo_irq_sel;

  // ---------------------------------------------------------------
  // Reset sources
  // ---------------------------------------------------------------
  wire wdt_reset = WDT_OVERFLOW && wdt_en_cfg;
  wire pin_reset = !EXT_RESET_N && rst_pin_en;
  wire any_reset = bo_reset || wdt_reset || pin_reset || POWER_UP_DETECT;

  // ---------------------------------------------------------------
  // Interrupt wake qualification
  // ---------------------------------------------------------------
  wire w_ext = qualify(WAKE_SRC.ext0, pwr_pkg::SRC_EXT0) ||
    qualify(WAKE_SRC.ext1, pwr_pkg::SRC_EXT1);
  wire w_kbd = SRC_SETUP.kbd_ready && qualify(WAKE_SRC.kbd, pwr_pkg::SRC_KBD);
  wire w_cmp = (SRC_SETUP.cmp1_ready && qualify(WAKE_SRC.cmp1, pwr_pkg::SRC_CMP1)) ||
    (SRC_SETUP.cmp2_ready && qualify(WAKE_SRC.cmp2, pwr_pkg::SRC_CMP2));
  wire w_wdt = !wdt_en_cfg && qualify(WAKE_SRC.wdt_irq, pwr_pkg::SRC_WDT);
  wire w_bo = qualify(bo_irq_evt, pwr_pkg::SRC_BO);
  wire w_adc = adc_rc_clock_select && SRC_SETUP.adc_ready &&
    qualify(WAKE_SRC.adc, pwr_pkg::SRC_ADC);
  wire irq_wake = w_ext || w_kbd || w_cmp || w_wdt || w_bo || w_adc;

  // Idle ends on any enabled interrupt, no priority check needed
  wire idle_wake = GLOBAL_IRQ_EN && ((|(ien_q & {WAKE_SRC.adc, bo_irq_evt, WAKE_SRC.wdt_irq,
    WAKE_SRC.cmp2, WAKE_SRC.cmp1, WAKE_SRC.kbd, WAKE_SRC.ext1, WAKE_SRC.ext0})));

  wire [pwr_pkg::SETTLE_W-1:0] settle_len = xtal_cfg ?
    pwr_pkg::SETTLE_W'(pwr_pkg::XTAL_SETTLE_CLKS - 1) :
    pwr_pkg::SETTLE_W'(pwr_pkg::RC_SETTLE_CLKS - 1);

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    power_control_reg_d = power_control_reg_q;
    if (wr_power_control_reg) begin
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_IDLE_BIT] = WDATA[pwr_pkg::POWER_CONTROL_REG_IDLE_BIT];
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_PD_BIT] = WDATA[pwr_pkg::POWER_CONTROL_REG_PD_BIT];
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_POF_BIT] = power_control_reg_q[pwr_pkg::POWER_CONTROL_REG_POF_BIT] &
        WDATA[pwr_pkg::POWER_CONTROL_REG_POF_BIT];
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_BOF_BIT] = power_control_reg_q[pwr_pkg::POWER_CONTROL_REG_BOF_BIT] &
        WDATA[pwr_pkg::POWER_CONTROL_REG_BOF_BIT];
    end
    if (POWER_UP_DETECT) begin
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_POF_BIT] = 1'b1;
    end
    if (bo_fall) begin
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_BOF_BIT] = 1'b1;
    end
    unique case (mode_q)
      pwr_pkg::ST_RUN: begin
        if (wr_power_control_reg && WDATA[pwr_pkg::POWER_CONTROL_REG_PD_BIT]) begin
          mode_d = pwr_pkg::ST_PDOWN;
        end else if (wr_power_control_reg && WDATA[pwr_pkg::POWER_CONTROL_REG_IDLE_BIT]) begin
          mode_d = pwr_pkg::ST_IDLE;
        end
      end
      pwr_pkg::ST_IDLE: begin
        if (idle_wake) begin
          mode_d = pwr_pkg::ST_RUN;
          power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_IDLE_BIT] = 1'b0;
        end
      end
      pwr_pkg::ST_PDOWN: begin
        if (irq_wake) begin
          mode_d = pwr_pkg::ST_SETTLE;
          settle_d = settle_len;
          power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_PD_BIT] = 1'b0;
        end
      end
      pwr_pkg::ST_SETTLE: begin
        if (settle_q == '0) begin
          mode_d = pwr_pkg::ST_RUN;
        end else begin
          settle_d = settle_q - 1'b1;
        end
      end
    endcase
    if (any_reset) begin
      mode_d = pwr_pkg::ST_RUN;
      settle_d = '0;
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_IDLE_BIT] = 1'b0;
      power_control_reg_d[pwr_pkg::POWER_CONTROL_REG_PD_BIT] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (RD) begin
      unique case (ADDR)
        pwr_pkg::ADDR_POWER_CONTROL: rdata_d = power_control_reg_q;
        pwr_pkg::ADDR_AUX_CONTROL: rdata_d = aux_q;
        pwr_pkg::ADDR_CONFIG: rdata_d = cfg_q;
        pwr_pkg::ADDR_IRQ_ENABLE: rdata_d = ien_q;
        pwr_pkg::ADDR_IRQ_PRIORITY: rdata_d = ipr_q;
        pwr_pkg::ADDR_STATUS: rdata_d = {4'h0, bo_low_q, 1'b0, mode_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      power_control_reg_q <= pwr_pkg::POWER_CONTROL_REG_RESET;
      mode_q <= pwr_pkg::ST_RUN;
      settle_q <= '0;
      bo_low_q <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      power_control_reg_q <= power_control_reg_d;
      mode_q <= mode_d;
      settle_q <= settle_d;
      bo_low_q <= bo_active;
      RDATA <= rdata_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aux_q <= pwr_pkg::AUX_RESET;
      cfg_q <= pwr_pkg::CFG_RESET;
      ien_q <= 8'h00;
      ipr_q <= 8'h00;
    end else begin
      if (wr_aux) aux_q <= WDATA & 8'h60;
      if (wr_cfg) cfg_q <= WDATA & 8'h1f;
      if (wr_ien) ien_q <= WDATA;
      if (wr_ipr) ipr_q <= WDATA;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CPU_HALT <= 1'b0;
      OSC_RUN <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      BROWNOUT_EN <= 1'b1;
      BROWNOUT_IRQ <= 1'b0;
      SYS_RESET <= 1'b0;
      WAKE_RESUME <= 1'b0;
    end else begin
      CPU_HALT <= mode_d != pwr_pkg::ST_RUN;
      OSC_RUN <= mode_d != pwr_pkg::ST_PDOWN;
      PERIPH_CLK_EN <= mode_d != pwr_pkg::ST_PDOWN;
      BROWNOUT_EN <= !bo_disable;
      BROWNOUT_IRQ <= bo_irq_evt;
      SYS_RESET <= any_reset;
      WAKE_RESUME <= (mode_q == pwr_pkg::ST_SETTLE) && (mode_d == pwr_pkg::ST_RUN);
    end
  end

endmodule // power_mode_wakeup_control
`default_nettype wire
